// >>> logic/tla_map.svh
`ifndef TLA_MAP_SVH
`define TLA_MAP_SVH
// Register byte offsets
`define TLA_REG_LOC_TEMP 8'h00
`define TLA_REG_REM_TEMP 8'h04
`define TLA_REG_LOC_LOW 8'h08
`define TLA_REG_LOC_HIGH 8'h0c
`define TLA_REG_REM_LOW 8'h10
`define TLA_REG_REM_HIGH 8'h14
`define TLA_REG_LOC_SHDN 8'h18
`define TLA_REG_REM_SHDN 8'h1c
`define TLA_REG_HYST 8'h20
`define TLA_REG_CONFIG 8'h24
`define TLA_REG_STATUS 8'h28
`define TLA_REG_MASK 8'h2c
`define TLA_REG_ARA 8'h30
// Status bit positions
`define TLA_ST_LOC_LOW 0
`define TLA_ST_LOC_HIGH 1
`define TLA_ST_REM_OPEN 2
`define TLA_ST_REM_LOW 3
`define TLA_ST_REM_HIGH 4
`define TLA_ST_LOC_SHDN 5
`define TLA_ST_REM_SHDN 6
// Config bit positions
`define TLA_CFG_ALERT_MASK 7
`define TLA_CFG_STANDBY 6
// Reset values and shorted-sensor result code
`define TLA_RST_LOW 8'h00
`define TLA_RST_HIGH 8'h55
`define TLA_RST_SHDN 8'h55
`define TLA_RST_HYST 8'h0a
`define TLA_RST_CONFIG 8'h00
`define TLA_RST_MASK 8'h00
`define TLA_SHORT_CODE 8'h80
// Pin input synchroniser depth
`define TLA_SYNC_STAGES 3
`endif

// >>> logic/tla_pkg.sv
package tla_pkg;
   typedef logic [7:0] tla_temp_t;
   typedef enum logic [1:0]
   {
      TLA_RD_IDLE = 2'b00,
      TLA_RD_RESP = 2'b01
   } tla_rd_state_e;
endpackage

// >>> logic/tla_pin_sync.sv
`timescale 1ns/1ps
`include "tla_map.svh"
// Three-stage pin synchroniser; changes once stages two and three agree
module tla_pin_sync
   import tla_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_in,
   output logic pin_out
);
   logic [`TLA_SYNC_STAGES-1:0] sync_ff;
   logic out_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sync_ff <= '0;
      else
         sync_ff <= {sync_ff[`TLA_SYNC_STAGES-2:0], pin_in};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         out_ff <= 1'b0;
      else if (sync_ff[1] == sync_ff[2])
         out_ff <= sync_ff[2];
   end

   assign pin_out = out_ff;
endmodule // tla_pin_sync

// >>> logic/tla_alert_core.sv
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "tla_map.svh"
// Contract
// (RL1) Alert asserts when a temperature is at or below its low limit.
// (RL2) No limit alert while every temperature is inside its limits.
// (RL3) Alert asserts when either temperature exceeds its high limit.
// (RL4) Fail-safe output asserts when either temperature exceeds its shutdown limit.
// (RL5) Alert is maskable; fail-safe output has no mask.
// (RL6) Separate shutdown limits for local and remote channels.
// (RL7) Software keeps each shutdown limit at or above its high limit.
// (RL8) Hysteresis resets to ten degrees and accepts any later write; a write without byte lane 0 is ignored.
// (RL9) One hysteresis value serves both fail-safe comparisons.
// (RL10) Hysteresis is an eight-bit unsigned count of whole degrees.
// (RL11) Open-sensor comparator sampled at conversion start sets status bit 2.
// (RL12) Remote input below range forces the remote result to 0x80.
// (RL13) Low limits reset to zero degrees so shorted sensor alerts.
// (RL14) Low test is less-or-equal, so -128 alerts even at minimum limit.
// (RL15) Fail-safe output only pulls low, open-drain.
// (RL16) Fail-safe releases once temperature falls to limit minus hysteresis.
// (RL17) Comparisons rerun on new results and on limit rewrites.
// (RL18) Alert response releases alert only if the cause is gone.
// (RL19) In standby, limit writes still compare stored values and may alert.
module tla_alert_core
   import tla_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [7:0] conv_local,
   input wire logic [7:0] conv_remote,
   input wire logic remote_below_range,
   input wire logic remote_open_pin,
   output logic standby,
   output logic alert_n_o,
   output logic alert_n_oe,
   output logic overtemp_failsafe_n_o,
   output logic overtemp_failsafe_n_oe,
   output logic irq
);
   tla_temp_t loc_temp_ff, rem_temp_ff;
   tla_temp_t loc_low_ff, loc_high_ff, rem_low_ff, rem_high_ff;
   tla_temp_t loc_shdn_ff, rem_shdn_ff, hyst_ff;
   logic [7:0] config_ff, status_ff, mask_ff, nxt_status;
   logic loc_overtemp_failsafe_n_ff, rem_overtemp_failsafe_n_ff, alert_ff, nxt_alert;
   logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [1:0] bresp_ff, rresp_ff;
   tla_rd_state_e rd_state_ff;
   logic remote_open, wr_fire, rd_fire, ara_ack;
   logic [7:0] cond, ev;

   tla_pin_sync u_open_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(remote_open_pin),
      .pin_out(remote_open)
   );

   // Write path: address and data taken in either order
   assign s_axi_awready = !aw_ff && !bvalid_ff;
   assign s_axi_wready = !w_ff && !bvalid_ff;
   assign wr_fire = aw_ff && w_ff && !bvalid_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ff <= 1'b0;
         awaddr_ff <= 8'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_ff <= 1'b1;
         awaddr_ff <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_ff <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_ff <= 1'b1;
         wdata_ff <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end
      else if (wr_fire)
         w_ff <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'b00;
      end
      else if (wr_fire)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (awaddr_ff > `TLA_REG_ARA || awaddr_ff[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end
      else if (s_axi_bready)
         bvalid_ff <= 1'b0;
   end

   // Byte lane 0 only; a write without lane 0 leaves the register alone
   logic s_axi_wstrb_ok_ff;
   logic wr_en;
   assign wr_en = wr_fire && s_axi_wstrb_ok_ff;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_wstrb_ok_ff <= 1'b0;
      else if (s_axi_wvalid && s_axi_wready)
         s_axi_wstrb_ok_ff <= s_axi_wstrb[0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         loc_low_ff <= `TLA_RST_LOW; // RL13
         rem_low_ff <= `TLA_RST_LOW; // RL13
         loc_high_ff <= `TLA_RST_HIGH;
         rem_high_ff <= `TLA_RST_HIGH;
         loc_shdn_ff <= `TLA_RST_SHDN; // RL6
         rem_shdn_ff <= `TLA_RST_SHDN; // RL6
         hyst_ff <= `TLA_RST_HYST; // RL8
         config_ff <= `TLA_RST_CONFIG;
         mask_ff <= `TLA_RST_MASK;
      end
      else if (wr_en)
      begin
         case (awaddr_ff)
            `TLA_REG_LOC_LOW: loc_low_ff <= wdata_ff[7:0];
            `TLA_REG_LOC_HIGH: loc_high_ff <= wdata_ff[7:0];
            `TLA_REG_REM_LOW: rem_low_ff <= wdata_ff[7:0];
            `TLA_REG_REM_HIGH: rem_high_ff <= wdata_ff[7:0];
            `TLA_REG_LOC_SHDN: loc_shdn_ff <= wdata_ff[7:0];
            `TLA_REG_REM_SHDN: rem_shdn_ff <= wdata_ff[7:0];
            `TLA_REG_HYST: hyst_ff <= wdata_ff[7:0]; // RL8 RL10
            `TLA_REG_CONFIG: config_ff <= wdata_ff[7:0];
            `TLA_REG_MASK: mask_ff <= wdata_ff[7:0];
            default: ;
         endcase
      end
   end

   assign standby = config_ff[`TLA_CFG_STANDBY];
   // Write to the alert-response register acts as the ARA answer
   assign ara_ack = wr_en && awaddr_ff == `TLA_REG_ARA; // RL18

   // Results latch only on a finished conversion, not in standby
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         loc_temp_ff <= 8'h00;
         rem_temp_ff <= 8'h00;
      end
      else if (conv_done && !standby)
      begin
         loc_temp_ff <= conv_local;
         rem_temp_ff <= remote_below_range ? `TLA_SHORT_CODE : conv_remote; // RL12
      end
   end

   // Live comparisons against stored results; limit rewrites act at once
   always_comb
   begin
      cond = 8'h00;
      cond[`TLA_ST_LOC_LOW] = $signed(loc_temp_ff) <= $signed(loc_low_ff); // RL1 RL14 RL17 RL19
      cond[`TLA_ST_REM_LOW] = $signed(rem_temp_ff) <= $signed(rem_low_ff); // RL1 RL14
      cond[`TLA_ST_LOC_HIGH] = $signed(loc_temp_ff) > $signed(loc_high_ff); // RL3 RL2
      cond[`TLA_ST_REM_HIGH] = $signed(rem_temp_ff) > $signed(rem_high_ff); // RL3
      cond[`TLA_ST_REM_OPEN] = status_ff[`TLA_ST_REM_OPEN];
      cond[`TLA_ST_LOC_SHDN] = loc_overtemp_failsafe_n_ff;
      cond[`TLA_ST_REM_SHDN] = rem_overtemp_failsafe_n_ff;
   end

   // Signed extended compare so limit minus hysteresis cannot wrap
   function automatic logic overtemp_failsafe_n_next(input logic cur, input tla_temp_t t, input tla_temp_t lim,
                                       input tla_temp_t hy);
      logic signed [9:0] tv, rel;
      tv = 10'($signed(t));
      rel = 10'($signed(lim)) - $signed({2'b00, hy});
      if (!cur)
         overtemp_failsafe_n_next = $signed(t) > $signed(lim); // RL4
      else
         overtemp_failsafe_n_next = !(tv <= rel); // RL16
   endfunction

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         loc_overtemp_failsafe_n_ff <= 1'b0;
         rem_overtemp_failsafe_n_ff <= 1'b0;
      end
      else
      begin
         loc_overtemp_failsafe_n_ff <= overtemp_failsafe_n_next(loc_overtemp_failsafe_n_ff, loc_temp_ff, loc_shdn_ff, hyst_ff); // RL9
         rem_overtemp_failsafe_n_ff <= overtemp_failsafe_n_next(rem_overtemp_failsafe_n_ff, rem_temp_ff, rem_shdn_ff, hyst_ff); // RL9
      end
   end

   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign ev = cond | ((conv_start && remote_open) ? (8'h01 << `TLA_ST_REM_OPEN) : 8'h00);

   // Sticky status, cleared by reading it except bit 2, cleared by a conversion start with no open sensor; a new event wins over the clear
   always_comb
   begin
      nxt_status = status_ff;
      if (rd_fire && s_axi_araddr == `TLA_REG_STATUS)
         nxt_status = 8'h00;
      nxt_status = nxt_status | ev; // RL11
      if (conv_start && !remote_open)
         nxt_status[`TLA_ST_REM_OPEN] = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_ff <= 8'h00;
      else
         status_ff <= nxt_status;
   end

   // Alert latches on an alert cause; response releases it only when clear
   logic alert_cause;
   assign alert_cause = |(cond & 8'h1f); // RL2
   always_comb
   begin
      nxt_alert = alert_ff;
      if (alert_cause)
         nxt_alert = 1'b1;
      else if (ara_ack)
         nxt_alert = 1'b0; // RL18
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         alert_ff <= 1'b0;
      else
         alert_ff <= nxt_alert;
   end

   // Open-drain: enable low means the pin is pulled low
   assign alert_n_o = 1'b0;
   assign alert_n_oe = !(alert_ff && !config_ff[`TLA_CFG_ALERT_MASK]); // RL5
   assign overtemp_failsafe_n_o = 1'b0; // RL15
   assign overtemp_failsafe_n_oe = !(loc_overtemp_failsafe_n_ff || rem_overtemp_failsafe_n_ff); // RL4 RL5 RL15
   assign irq = |(status_ff & ~mask_ff);

   // Read path: one-cycle answer
   assign s_axi_arready = rd_state_ff == TLA_RD_IDLE;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state_ff <= TLA_RD_IDLE;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= 2'b00;
      end
      else
      begin
         case (rd_state_ff)
            TLA_RD_IDLE:
               if (rd_fire)
               begin
                  rd_state_ff <= TLA_RD_RESP;
                  rresp_ff <= 2'b00;
                  case (s_axi_araddr)
                     `TLA_REG_LOC_TEMP: rdata_ff <= {24'h000000, loc_temp_ff};
                     `TLA_REG_REM_TEMP: rdata_ff <= {24'h000000, rem_temp_ff};
                     `TLA_REG_LOC_LOW: rdata_ff <= {24'h000000, loc_low_ff};
                     `TLA_REG_LOC_HIGH: rdata_ff <= {24'h000000, loc_high_ff};
                     `TLA_REG_REM_LOW: rdata_ff <= {24'h000000, rem_low_ff};
                     `TLA_REG_REM_HIGH: rdata_ff <= {24'h000000, rem_high_ff};
                     `TLA_REG_LOC_SHDN: rdata_ff <= {24'h000000, loc_shdn_ff};
                     `TLA_REG_REM_SHDN: rdata_ff <= {24'h000000, rem_shdn_ff};
                     `TLA_REG_HYST: rdata_ff <= {24'h000000, hyst_ff};
                     `TLA_REG_CONFIG: rdata_ff <= {24'h000000, config_ff};
                     `TLA_REG_STATUS: rdata_ff <= {24'h000000, status_ff};
                     `TLA_REG_MASK: rdata_ff <= {24'h000000, mask_ff};
                     `TLA_REG_ARA: rdata_ff <= {31'h00000000, alert_ff};
                     default:
                     begin
                        rdata_ff <= 32'h0000_0000;
                        rresp_ff <= 2'b10;
                     end
                  endcase
               end
            TLA_RD_RESP:
               if (s_axi_rready)
                  rd_state_ff <= TLA_RD_IDLE;
            default: rd_state_ff <= TLA_RD_IDLE;
         endcase
      end
   end

   assign rvalid_ff = rd_state_ff == TLA_RD_RESP;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   AST_HIGH_ALERT: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      $signed(rem_temp_ff) > $signed(rem_high_ff) |=> alert_ff)
      else $error("High remote temp did not latch alert");
   AST_LOW_ALERT: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
      $signed(loc_temp_ff) <= $signed(loc_low_ff) |=> alert_ff)
      else $error("Low local temp did not latch alert");
   AST_SHORT_CODE: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
      conv_done && !standby && remote_below_range |=> rem_temp_ff == 8'h80)
      else $error("Shorted remote not forced to -128");
   AST_NO_ALERT_INSIDE: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
      !alert_ff && !alert_cause |=> !alert_ff)
      else $error("Alert raised with no cause");
   AST_OVERTEMP_FAILSAFE_N_SET: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
      $signed(loc_temp_ff) > $signed(loc_shdn_ff) |=> !overtemp_failsafe_n_oe)
      else $error("Fail-safe not asserted above limit");
   AST_OVERTEMP_FAILSAFE_N_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
      loc_overtemp_failsafe_n_ff && $signed(10'($signed(loc_temp_ff))) >
      $signed(10'($signed(loc_shdn_ff)) - $signed({2'b00, hyst_ff})) |=> loc_overtemp_failsafe_n_ff)
      else $error("Fail-safe released inside hysteresis band");
   AST_MASK: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
      config_ff[`TLA_CFG_ALERT_MASK] |-> alert_n_oe)
      else $error("Masked alert still drives pin");
   AST_OPEN_STATUS: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
      conv_start && remote_open |=> status_ff[`TLA_ST_REM_OPEN])
      else $error("Open sensor not flagged");
   AST_ARA_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // RL18
      ara_ack && alert_cause |=> alert_ff)
      else $error("Alert released while cause persists");
   COV_ALERT: cover property (@(posedge aclk) disable iff (!aresetn) $fell(alert_n_oe));
   COV_OVERTEMP_FAILSAFE_N: cover property (@(posedge aclk) disable iff (!aresetn) $rose(overtemp_failsafe_n_oe));
   COV_ARA: cover property (@(posedge aclk) disable iff (!aresetn) ara_ack ##1 !alert_ff);
endmodule // tla_alert_core

// >>> sim/tla_host_model.sv
`timescale 1ns/1ps
module tla_host_model
(
   input wire logic alert_n_o,
   input wire logic alert_n_oe,
   input wire logic overtemp_failsafe_n_o,
   input wire logic overtemp_failsafe_n_oe,
   output logic alert_line,
   output logic failsafe_line
);
   // Host side pull-ups: a released line reads high
   assign alert_line = alert_n_oe ? 1'b1 : alert_n_o;
   assign failsafe_line = overtemp_failsafe_n_oe ? 1'b1 : overtemp_failsafe_n_o;
endmodule // tla_host_model

// >>> sim/temp_limit_alert_logic_bench.sv
`timescale 1ns/1ps
`include "tla_map.svh"
module temp_limit_alert_logic_bench;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, cl = 8'h00, cr = 8'h00, lt, rt;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, standby, a_o, a_oe, f_o, f_oe, irq, a_line, f_line;
   logic cs = 1'b0, cd = 1'b0, below = 1'b0, open_pin = 1'b0, al, fl, fr;
   logic [1:0] bresp, rresp;
   logic [3:0] strb = 4'hf;
   logic [7:0] sh [0:12];
   int fail_count = 0, n_checks = 0;
   always #2.5 aclk = ~aclk;
   tla_alert_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_start(cs), .conv_done(cd),
      .conv_local(cl), .conv_remote(cr), .remote_below_range(below), .remote_open_pin(open_pin),
      .standby(standby), .alert_n_o(a_o), .alert_n_oe(a_oe), .overtemp_failsafe_n_o(f_o),
      .overtemp_failsafe_n_oe(f_oe), .irq(irq));
   tla_host_model i_host (.alert_n_o(a_o), .alert_n_oe(a_oe), .overtemp_failsafe_n_o(f_o),
      .overtemp_failsafe_n_oe(f_oe), .alert_line(a_line), .failsafe_line(f_line));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   function automatic logic cause();
      cause = $signed(lt) <= $signed(sh[2]) || $signed(lt) > $signed(sh[3]) ||
         $signed(rt) <= $signed(sh[4]) || $signed(rt) > $signed(sh[5]);
   endfunction
   // Set above the limit, hold until at or below limit minus hysteresis
   function automatic logic fs_next(input logic st, input logic [7:0] t, input logic [7:0] lim);
      fs_next = ($signed(t) > $signed(lim)) || (st && int'($signed(t)) > int'($signed(lim)) - int'(sh[8]));
   endfunction
   task automatic eval();
      al = al | cause();
      fl = fs_next(fl, lt, sh[6]);
      fr = fs_next(fr, rt, sh[7]);
   endtask
   // Both channels handed over at once; response awaited with the ready still up
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      int n;
      n = 0;
      tb = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb && n < 100)
      begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         r = bresp;
         n++;
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (tb)
            bready <= 1'b0;
      end
      // One idle edge so a following call never re-raises bready in this step
      @(posedge aclk);
      if (!tb)
         fail_count++;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      int n;
      n = 0;
      tr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr && n < 100)
      begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         n++;
         @(posedge aclk);
         if (ta)
            arvalid <= 1'b0;
         if (tr)
            rready <= 1'b0;
      end
      @(posedge aclk);
      if (!tr)
         fail_count++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axw(a, {24'h0, d}, r);
      chk({30'h0, r}, 32'h0);
      if (a == `TLA_REG_ARA)
         al = cause();
      else
         sh[a[7:2]] = d;
      eval();
   endtask
   task automatic conv(input logic [7:0] l, input logic [7:0] r, input logic b);
      cl <= l;
      cr <= r;
      below <= b;
      cs <= 1'b1;
      @(posedge aclk);
      cs <= 1'b0;
      cd <= 1'b1;
      @(posedge aclk);
      cd <= 1'b0;
      if (!sh[9][6])
      begin
         lt = l;
         rt = b ? `TLA_SHORT_CODE : r;
      end
      eval();
   endtask
   task automatic pins();
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      chk1(a_line, !(al && !sh[9][7]));
      chk1(f_line, !(fl || fr));
      @(posedge aclk);
   endtask
   task automatic irq_is(input logic e);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk1(irq, e);
      @(posedge aclk);
   endtask
   initial
   begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] tbl [0:11];
      sh = '{8'h0, 8'h0, `TLA_RST_LOW, `TLA_RST_HIGH, `TLA_RST_LOW, `TLA_RST_HIGH, `TLA_RST_SHDN,
         `TLA_RST_SHDN, `TLA_RST_HYST, `TLA_RST_CONFIG, 8'h0, `TLA_RST_MASK, 8'h0};
      al = 1'b0;
      fl = 1'b0;
      fr = 1'b0;
      lt = 8'h00;
      rt = 8'h00;
      void'($urandom(32'hd2649ad9));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 2; i < 12; i++)
      begin
         axr(8'(i * 4), d, r);
         if (i != 10)
            chk(d, {24'h0, sh[i]});
      end
      axr(8'h34, d, r);
      chk({30'h0, r}, 32'h2);
      axw(8'h09, 32'h7f, r);
      chk({30'h0, r}, 32'h2);
      conv(8'd25, 8'd30, 1'b0);
      wr(`TLA_REG_ARA, 8'h00);
      pins();
      conv(8'h00, 8'd30, 1'b0);
      pins();
      conv(8'd25, 8'd30, 1'b0);
      pins();
      wr(`TLA_REG_ARA, 8'h00);
      pins();
      conv(8'h55, 8'h56, 1'b0);
      pins();
      axr(`TLA_REG_STATUS, d, r);
      chk(d & 32'h12, 32'h10);
      conv(8'd25, 8'h10, 1'b1);
      axr(`TLA_REG_REM_TEMP, d, r);
      chk(d, 32'h80);
      pins();
      wr(`TLA_REG_REM_LOW, 8'h80);
      wr(`TLA_REG_ARA, 8'h00);
      pins();
      wr(`TLA_REG_REM_LOW, 8'h00);
      wr(`TLA_REG_REM_SHDN, 8'h60);
      wr(`TLA_REG_HYST, 8'h05);
      strb <= 4'he;
      axw(`TLA_REG_HYST, 32'h33, r);
      chk({30'h0, r}, 32'h0);
      strb <= 4'hf;
      axr(`TLA_REG_HYST, d, r);
      chk(d, 32'h5);
      tbl = '{8'd25, 8'h61, 8'd25, 8'h5c, 8'd25, 8'h5b, 8'h56, 8'd25, 8'h51, 8'd25, 8'h50, 8'd25};
      for (int i = 0; i < 12; i += 2)
      begin
         conv(tbl[i], tbl[i + 1], 1'b0);
         pins();
      end
      wr(`TLA_REG_CONFIG, 8'h80);
      conv(8'd25, 8'h70, 1'b0);
      pins();
      wr(`TLA_REG_CONFIG, 8'h00);
      conv(8'd25, 8'd30, 1'b0);
      wr(`TLA_REG_ARA, 8'h00);
      wr(`TLA_REG_CONFIG, 8'h40);
      chk1(standby, 1'b1);
      conv(8'h70, 8'h70, 1'b0);
      pins();
      wr(`TLA_REG_LOC_HIGH, 8'h10);
      pins();
      wr(`TLA_REG_LOC_HIGH, 8'h55);
      wr(`TLA_REG_CONFIG, 8'h00);
      wr(`TLA_REG_ARA, 8'h00);
      axr(`TLA_REG_STATUS, d, r);
      conv(8'h00, 8'd30, 1'b0);
      irq_is(1'b1);
      wr(`TLA_REG_MASK, 8'h01);
      irq_is(1'b0);
      conv(8'd25, 8'd30, 1'b0);
      axr(`TLA_REG_STATUS, d, r);
      wr(`TLA_REG_MASK, 8'h00);
      irq_is(1'b0);
      repeat (24)
      begin
         conv(8'($urandom), 8'($urandom), 1'b0);
         wr(`TLA_REG_ARA, 8'h00);
         pins();
      end
      open_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      conv(8'd25, 8'd30, 1'b0);
      axr(`TLA_REG_STATUS, d, r);
      chk(d & 32'h4, 32'h4);
      open_pin <= 1'b0;
      repeat (6) @(posedge aclk);
      conv(8'd25, 8'd30, 1'b0);
      axr(`TLA_REG_STATUS, d, r);
      chk(d & 32'h4, 32'h0);
      end_sim();
   end
   // Whole run needs under six hundred cycles
   initial
   begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      end_sim();
   end
endmodule // temp_limit_alert_logic_bench
